// File: core/dswp_defines.svh
// Constants of the serial write port: offsets, field positions, reset values, timing
`ifndef DSWP_DEFINES_SVH
`define DSWP_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define DSWP_OFF_CODE 8'h00
`define DSWP_OFF_STATUS 8'h04
`define DSWP_OFF_CTRL 8'h08
`define DSWP_OFF_FRAMES 8'h0C

// ---------------------------------------------------------------
// Register fields and reset values
// ---------------------------------------------------------------
`define DSWP_STAT_MODE_HI 1
`define DSWP_STAT_MODE_LO 0
`define DSWP_STAT_ABORT 2
`define DSWP_STAT_SETTLED 3
`define DSWP_STAT_BUSY 4
`define DSWP_CTRL_EN 0
`define DSWP_CTRL_EN_RST 1'h1

// ---------------------------------------------------------------
// Frame layout
// ---------------------------------------------------------------
`define DSWP_LONG_LEN 24
`define DSWP_SHORT_LEN 16
`define DSWP_LONG_FRAME_MODE_HI 17
`define DSWP_LONG_FRAME_MODE_LO 16
`define DSWP_SHORT_FRAME_MODE_HI 15
`define DSWP_SHORT_FRAME_MODE_LO 14

// ---------------------------------------------------------------
// Timing, pins, buffer
// ---------------------------------------------------------------
`define DSWP_T_EXIT_NS 5000
`define DSWP_CLK_MHZ 50
`define DSWP_NS_PER_US 1000
`define DSWP_PIN_RST 3'h2
`define DSWP_PIN_SCLK 2
`define DSWP_PIN_SYNC 1
`define DSWP_PIN_DIN 0
`define DSWP_BUF_DEPTH 2'h2

`endif

// File: core/dswp_pkg.sv
// Types shared by the serial write port modules
package dswp_pkg;

    // ---------------------------------------------------------------
    // Enumerations
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SHIFT = 3'h2,
        ST_DONE = 3'h4
    } dswp_state_t;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_PD_1K = 2'h1,
        MODE_PD_100K = 2'h2,
        MODE_PD_TRI = 2'h3
    } dswp_mode_t;

    // ---------------------------------------------------------------
    // Carriers and module state
    // ---------------------------------------------------------------
    typedef struct packed {
        dswp_mode_t mode;
        logic [15:0] code;
    } dswp_frame_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } dswp_sync_t;

    typedef struct packed {
        dswp_frame_t [1:0] ent;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } dswp_buf_t;

    typedef struct packed {
        dswp_state_t state;
        logic [23:0] sh;
        logic [4:0] cnt;
        logic pend;
        dswp_frame_t pword;
        logic sclk_q;
        logic sync_q;
        logic [15:0] code;
        dswp_mode_t mode;
        logic [8:0] settle;
        logic abort;
        logic [15:0] frames;
        logic enable;
        logic [31:0] prdata;
    } dswp_top_t;

endpackage : dswp_pkg

// File: core/dswp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dswp_sync #(
    parameter logic RST_LVL = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Pin and filtered level
    input wire logic pin_in,
    output logic lvl_out
);
    dswp_pkg::dswp_sync_t q;
    dswp_pkg::dswp_sync_t n;

    // Stage one is read only by stage two; the level moves once stages two and three agree
    always_comb begin
        n = q;
        n.s1 = pin_in;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) begin
            n.lvl = q.s3;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            q <= '{s1: RST_LVL, s2: RST_LVL, s3: RST_LVL, lvl: RST_LVL};
        end else begin
            q <= n;
        end
    end

    assign lvl_out = q.lvl;

endmodule : dswp_sync

// File: core/dswp_buf.sv
// Two-entry frame buffer between the serial decoder and the converter core
`timescale 1ns/1ps
`include "dswp_defines.svh"
module dswp_buf (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Filling side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input dswp_pkg::dswp_frame_t in_data_in,
    // Draining side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output dswp_pkg::dswp_frame_t out_data_out
);
    dswp_pkg::dswp_buf_t q;
    dswp_pkg::dswp_buf_t n;
    logic push;
    logic pop;

    // Handshakes straight from the fill count
    assign in_ready_out = (q.cnt != `DSWP_BUF_DEPTH);
    assign out_valid_out = (q.cnt != 2'h0);
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    // Pointer and count update
    always_comb begin
        n = q;
        if (push) begin
            n.ent[q.wp] = in_data_in;
            n.wp = ~q.wp;
        end
        if (pop) begin
            n.rp = ~q.rp;
        end
        n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign out_data_out = q.ent[q.rp];

endmodule : dswp_buf

// File: core/dswp_top.sv
// Serial write port of a single-channel converter with APB status and control
//
// Summary of operation
// - Falling frame sync starts a frame and arms the input shift register; here only while enabled and with no completed frame held.
// - While sync is low, each falling serial clock shifts one data bit in.
// - On the 16th or 24th falling edge the frame executes immediately; here it waits in the two-entry buffer until core_ready_in is high.
// - Short frame: first two bits are mode, next 14 or 12 are data.
// - Long frame: six ignored bits, two mode bits, then 16 data bits.
// - Frames arrive most significant bit first.
// - Sync rising before the last edge clears the shift register, discards the frame.
// - Mode 00 normal, 01 1k to ground, 10 100k, 11 three-state.
// - Power-down disconnects the amplifier and applies the selected termination.
// - Power-down leaves the stored code untouched.
// - Reset code is zero or midscale and holds until a valid frame.
// - Code is straight binary over the full resolution range.
// - Leaving power-down flags the output unsettled for 5 us.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "dswp_defines.svh"
module dswp_top #(
    parameter int RES = 16,
    parameter bit MIDSCALE = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Serial link pins
    input wire logic sclk_in,
    input wire logic sync_n_in,
    input wire logic din_in,
    // Converter core
    input wire logic core_ready_in,
    output logic [15:0] dac_code_out,
    output dswp_pkg::dswp_mode_t mode_out,
    output logic amp_to_pin_out,
    output logic term_1k_out,
    output logic term_100k_out,
    output logic out_settled_out
);
    // ---------------------------------------------------------------
    // Variant constants
    // ---------------------------------------------------------------
    localparam bit LONG = (RES == 16);
    localparam int FRAME_LEN = LONG ? `DSWP_LONG_LEN : `DSWP_SHORT_LEN;
    localparam logic [4:0] LAST = 5'(FRAME_LEN);
    localparam int SHORT_SHIFT = LONG ? 0 : (`DSWP_SHORT_FRAME_MODE_LO - RES);
    localparam logic [15:0] CODE_MASK = 16'((32'h1 << RES) - 32'h1);
    localparam logic [15:0] RST_CODE = MIDSCALE ? 16'(32'h1 << (RES - 1)) : 16'h0000;
    localparam int EXIT_CYC =
        (`DSWP_T_EXIT_NS * `DSWP_CLK_MHZ + `DSWP_NS_PER_US - 1) / `DSWP_NS_PER_US;
    localparam logic [8:0] S_EXIT = 9'(EXIT_CYC);

    localparam dswp_pkg::dswp_top_t RST = '{
        state: dswp_pkg::ST_DONE,
        sh: 24'h000000,
        cnt: 5'h00,
        pend: 1'b0,
        pword: '{mode: dswp_pkg::MODE_NORMAL, code: 16'h0000},
        sclk_q: 1'b0,
        sync_q: 1'b1,
        code: RST_CODE,
        mode: dswp_pkg::MODE_NORMAL,
        settle: 9'h000,
        abort: 1'b0,
        frames: 16'h0000,
        enable: `DSWP_CTRL_EN_RST,
        prdata: 32'h00000000
    };

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------

    // Address decode, used only by the error answer; the read mux decodes the address in its own case
    function automatic logic addr_ok(input logic [7:0] a);
        return (a == `DSWP_OFF_CODE) || (a == `DSWP_OFF_STATUS) ||
               (a == `DSWP_OFF_CTRL) || (a == `DSWP_OFF_FRAMES);
    endfunction : addr_ok

    // Split a completed word into mode and code
    function automatic dswp_pkg::dswp_frame_t decode_frame(input logic [23:0] w);
        dswp_pkg::dswp_frame_t f;
        logic [13:0] d;
        d = w[`DSWP_SHORT_FRAME_MODE_LO-1:0];
        if (LONG) begin
            f.mode = dswp_pkg::dswp_mode_t'(
                w[`DSWP_LONG_FRAME_MODE_HI:`DSWP_LONG_FRAME_MODE_LO]);
            f.code = w[`DSWP_LONG_FRAME_MODE_LO-1:0];
        end else begin
            f.mode = dswp_pkg::dswp_mode_t'(
                w[`DSWP_SHORT_FRAME_MODE_HI:`DSWP_SHORT_FRAME_MODE_LO]);
            f.code = 16'(d >> SHORT_SHIFT);
        end
        f.code = f.code & CODE_MASK;
        return f;
    endfunction : decode_frame

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    localparam logic [2:0] PIN_RST = `DSWP_PIN_RST;
    logic [2:0] pin_raw;
    logic [2:0] pin_lvl;
    assign pin_raw = {sclk_in, sync_n_in, din_in};

    // Serial clock is oversampled, so the link must stay well below the system rate
    generate
        for (genvar i = 0; i < 3; i++) begin : g_pin
            dswp_sync #(.RST_LVL(PIN_RST[i])) u_sync (
                .clk_sys_in(clk_sys_in),
                .reset_in(reset_in),
                .pin_in(pin_raw[i]),
                .lvl_out(pin_lvl[i])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // State and edges
    // ---------------------------------------------------------------
    dswp_pkg::dswp_top_t q;
    dswp_pkg::dswp_top_t n;
    logic sclk_l;
    logic sync_l;
    logic din_l;
    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;
    logic [23:0] shifted;
    logic buf_in_ready;
    logic buf_out_valid;
    dswp_pkg::dswp_frame_t buf_out;
    logic drain;
    logic apb_setup;
    logic apb_write;

    // Edge detection on filtered levels
    assign sclk_l = pin_lvl[`DSWP_PIN_SCLK];
    assign sync_l = pin_lvl[`DSWP_PIN_SYNC];
    assign din_l = pin_lvl[`DSWP_PIN_DIN];
    assign sclk_fall = q.sclk_q & ~sclk_l;
    assign sync_fall = q.sync_q & ~sync_l;
    assign sync_rise = ~q.sync_q & sync_l;
    assign shifted = {q.sh[22:0], din_l};
    assign drain = buf_out_valid & core_ready_in;
    assign apb_setup = psel_in & ~penable_in;
    assign apb_write = psel_in & penable_in & pwrite_in;

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        n = q;
        n.sclk_q = sclk_l;
        n.sync_q = sync_l;

        // APB read data is latched in the setup phase, shown in the access phase
        if (apb_setup && !pwrite_in) begin
            n.prdata = 32'h00000000;
            unique case (paddr_in)
                `DSWP_OFF_CODE: n.prdata = {16'h0000, q.code};
                `DSWP_OFF_STATUS: begin
                    n.prdata[`DSWP_STAT_MODE_HI:`DSWP_STAT_MODE_LO] = q.mode;
                    n.prdata[`DSWP_STAT_ABORT] = q.abort;
                    n.prdata[`DSWP_STAT_SETTLED] = (q.settle == 9'h000);
                    n.prdata[`DSWP_STAT_BUSY] = q.pend | buf_out_valid;
                end
                `DSWP_OFF_CTRL: n.prdata[`DSWP_CTRL_EN] = q.enable;
                `DSWP_OFF_FRAMES: n.prdata = {16'h0000, q.frames};
                default: n.prdata = 32'h00000000;
            endcase
        end

        // Writes take effect in the access phase; clears come first so a set wins
        if (apb_write) begin
            if (paddr_in == `DSWP_OFF_CTRL) begin
                n.enable = pwdata_in[`DSWP_CTRL_EN];
            end
            if (paddr_in == `DSWP_OFF_STATUS && pwdata_in[`DSWP_STAT_ABORT]) begin
                n.abort = 1'b0;
            end
        end

        // Completed frame leaves for the buffer when it has room
        if (q.pend && buf_in_ready) begin
            n.pend = 1'b0;
        end

        // Frame sequencer
        unique case (q.state)
            dswp_pkg::ST_IDLE: begin
                // A held frame stalls the next start so no word is overwritten
                if (sync_fall && q.enable && !q.pend) begin
                    n.state = dswp_pkg::ST_SHIFT;
                    n.sh = 24'h000000;
                    n.cnt = 5'h00;
                end
            end
            dswp_pkg::ST_SHIFT: begin
                if (sync_rise) begin
                    n.state = dswp_pkg::ST_IDLE;
                    n.sh = 24'h000000;
                    n.cnt = 5'h00;
                    n.abort = 1'b1;
                end else if (sclk_fall) begin
                    n.sh = shifted;
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt + 5'h01 == LAST) begin
                        n.pend = 1'b1;
                        n.pword = decode_frame(shifted);
                        n.state = dswp_pkg::ST_DONE;
                    end
                end
            end
            dswp_pkg::ST_DONE: begin
                // Sync may idle low here; clocks are ignored until it rises
                if (sync_l) begin
                    n.state = dswp_pkg::ST_IDLE;
                end
            end
            default: n.state = dswp_pkg::ST_IDLE;
        endcase

        // Power-up settling countdown
        if (q.settle != 9'h000) begin
            n.settle = q.settle - 9'h001;
        end

        // Core accepts a frame: mode always, code only in normal mode
        if (drain) begin
            n.mode = buf_out.mode;
            n.frames = q.frames + 16'h0001;
            if (buf_out.mode == dswp_pkg::MODE_NORMAL) begin
                n.code = buf_out.code;
                if (q.mode != dswp_pkg::MODE_NORMAL) begin
                    n.settle = S_EXIT;
                end
            end
        end
    end

    // State register; reset gives the variant code and normal mode
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            q <= RST;
        end else begin
            q <= n;
        end
    end

    // ---------------------------------------------------------------
    // Frame buffer
    // ---------------------------------------------------------------
    dswp_buf u_buf (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .in_valid_in(q.pend),
        .in_ready_out(buf_in_ready),
        .in_data_in(q.pword),
        .out_valid_out(buf_out_valid),
        .out_ready_in(core_ready_in),
        .out_data_out(buf_out)
    );

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign prdata_out = q.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_ok(paddr_in);
    assign dac_code_out = q.code;
    assign mode_out = q.mode;

    // Termination follows the mode; the amplifier drives only in normal mode
    assign amp_to_pin_out = (q.mode == dswp_pkg::MODE_NORMAL);
    assign term_1k_out = (q.mode == dswp_pkg::MODE_PD_1K);
    assign term_100k_out = (q.mode == dswp_pkg::MODE_PD_100K);
    assign out_settled_out = (q.settle == 9'h000);

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    start_on_fall_a: assert property (
        q.state == dswp_pkg::ST_IDLE && sync_fall && q.enable && !q.pend
        |=> q.state == dswp_pkg::ST_SHIFT && q.cnt == 5'h00)
        else $error("frame did not start on sync fall");

    shift_bit_a: assert property (
        q.state == dswp_pkg::ST_SHIFT && sclk_fall && !sync_rise
        |=> q.cnt == $past(q.cnt) + 5'h01 && q.sh[0] == $past(din_l))
        else $error("bit not shifted on clock fall");

    exec_last_a: assert property (
        q.state == dswp_pkg::ST_SHIFT && sclk_fall && !sync_rise && q.cnt == LAST - 5'h01
        |=> q.pend && q.state == dswp_pkg::ST_DONE)
        else $error("frame not executed on last edge");

    mode_field_a: assert property (
        $rose(q.pend) |-> q.pword.mode == (LONG ?
            q.sh[`DSWP_LONG_FRAME_MODE_HI:`DSWP_LONG_FRAME_MODE_LO] :
            q.sh[`DSWP_SHORT_FRAME_MODE_HI:`DSWP_SHORT_FRAME_MODE_LO]))
        else $error("mode field taken from wrong bits");

    msb_first_a: assert property (
        $rose(q.pend) && LONG |-> q.pword.code == q.sh[15:0])
        else $error("data bits out of order");

    abort_drop_a: assert property (
        q.state == dswp_pkg::ST_SHIFT && sync_rise
        |=> q.state == dswp_pkg::ST_IDLE && q.sh == 24'h000000 && !q.pend)
        else $error("aborted frame not discarded");

    term_sel_a: assert property (
        q.mode != dswp_pkg::MODE_NORMAL |-> !amp_to_pin_out &&
        term_1k_out == (q.mode == dswp_pkg::MODE_PD_1K) &&
        term_100k_out == (q.mode == dswp_pkg::MODE_PD_100K))
        else $error("wrong termination in power-down");

    pd_keeps_code_a: assert property (
        drain && buf_out.mode != dswp_pkg::MODE_NORMAL |=> q.code == $past(q.code))
        else $error("power-down changed the stored code");

    reset_hold_a: assert property (
        q.frames == 16'h0000 |-> q.code == RST_CODE && q.mode == dswp_pkg::MODE_NORMAL)
        else $error("reset code or mode lost before first frame");

    code_range_a: assert property (
        (dac_code_out & ~CODE_MASK) == 16'h0000)
        else $error("code outside resolution range");

    settle_wait_a: assert property (
        q.settle == S_EXIT |=> !out_settled_out [*8])
        else $error("output flagged settled too early");

    ignore_after_a: assert property (
        q.state == dswp_pkg::ST_DONE && !sync_l |=> q.state == dswp_pkg::ST_DONE)
        else $error("clocks after execution not ignored");

    frame_done_c: cover property ($rose(q.pend));
    frame_abort_c: cover property (q.state == dswp_pkg::ST_SHIFT && sync_rise);
    pd_exit_c: cover property (q.settle == S_EXIT);
    buf_full_c: cover property (!buf_in_ready && q.pend);

endmodule : dswp_top

// File: testbench/dswp_host.sv
// Behavioural serial host that writes frames into the converter port
`timescale 1ns/1ps
module dswp_host (
    // Serial pins
    output logic sclk_out,
    output logic sync_n_out,
    output logic din_out
);
    // Clock stands still low outside frames; data shows the inverse of the last bit
    initial begin
        sclk_out = 1'b0;
        sync_n_out = 1'b1;
        din_out = 1'b0;
    end

    // Sends cut bits of a 24-bit frame; a short cut aborts, hold keeps sync low
    task automatic send(input logic [23:0] w, input int cut, input bit start, input bit hold);
        // Every change lands on a system clock edge by non-blocking assignment, so no race
        if (start) begin
            sync_n_out <= 1'b1;
            #300;
            sync_n_out <= 1'b0;
            #200;
        end
        // 160 ns period stays far below the 30 MHz ceiling
        for (int i = 23; i > 23 - cut; i--) begin
            din_out <= w[i];
            #20 sclk_out <= 1'b1;
            #80 sclk_out <= 1'b0;
            #60;
        end
        din_out <= ~din_out;
        #200;
        if (!hold) sync_n_out <= 1'b1;
        #300;
    endtask : send
endmodule : dswp_host

// File: testbench/testbench.sv
// Self-checking bench of the serial write port
`timescale 1ns/1ps
module testbench;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic core_ready = 1'b1;
    logic sclk, sync_n, din, pready, pslverr, amp, t1k, t100k, settled, err;
    logic [31:0] prdata, rd;
    logic [15:0] code;
    dswp_pkg::dswp_mode_t mode;
    logic [15:0] code2;
    dswp_pkg::dswp_mode_t mode2;
    logic [23:0] fr [3] = '{24'hFCA5C3, 24'h00FFFF, 24'hC00001};
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    // 50 MHz system clock
    always #10 clk_sys_in = ~clk_sys_in;

    dswp_host host (.sclk_out(sclk), .sync_n_out(sync_n), .din_out(din));

    dswp_top DUT (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .sclk_in(sclk), .sync_n_in(sync_n), .din_in(din),
        .core_ready_in(core_ready), .dac_code_out(code), .mode_out(mode),
        .amp_to_pin_out(amp), .term_1k_out(t1k), .term_100k_out(t100k),
        .out_settled_out(settled)
    );

    // Short-frame 12-bit variant on the same pins and bus, reset to midscale
    dswp_top #(.RES(12), .MIDSCALE(1'b1)) dut_short (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(),
        .pready_out(), .pslverr_out(),
        .sclk_in(sclk), .sync_n_in(sync_n), .din_in(din),
        .core_ready_in(core_ready), .dac_code_out(code2), .mode_out(mode2),
        .amp_to_pin_out(), .term_1k_out(), .term_100k_out(),
        .out_settled_out()
    );

    // Value compare, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000, rd, err);
        chk(rd, exp);
    endtask : rd_chk

    // Waits a bounded time for the core outputs to reach a mode and code
    task automatic wait_out(input logic [1:0] m, input logic [15:0] c);
        for (int i = 0; i < 60 && {mode, code} !== {m, c}; i++) begin
            @(posedge clk_sys_in);
        end
        chk({mode, code}, {m, c});
    endtask : wait_out

    task automatic end_of_test;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Hang guard, several times the expected run length
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("Error %0t: timeout", $time);
            end_of_test();
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        rd_chk(8'h00, 32'h00000000);
        rd_chk(8'h04, 32'h00000008);
        rd_chk(8'h08, 32'h00000001);
        chk(code2, 16'h0800);
        chk(amp, 1'b1);
        apb(1'b0, 8'h10, 32'h00000000, rd, err);
        chk(err, 1'b1);
        // Ignored top bits set, full scale and single LSB codes
        foreach (fr[i]) begin
            host.send(fr[i], 24, 1, 0);
            wait_out(fr[i][17:16], fr[i][15:0]);
        end
        host.send(24'h001234, 10, 1, 0);
        chk(code, 16'h0001);
        rd_chk(8'h04, 32'h0000000C);
        apb(1'b1, 8'h04, 32'h00000004, rd, err);
        rd_chk(8'h04, 32'h00000008);
        for (int m = 1; m < 4; m++) begin
            host.send({6'h00, m[1:0], 16'h5555}, 24, 1, 0);
            wait_out(m[1:0], 16'h0001);
            chk({amp, t1k, t100k}, {1'b0, m == 1, m == 2});
        end
        host.send(24'h007777, 24, 1, 0);
        wait_out(2'h0, 16'h7777);
        chk(settled, 1'b0);
        repeat (220) @(posedge clk_sys_in);
        chk(settled, 1'b0);
        repeat (40) @(posedge clk_sys_in);
        chk(settled, 1'b1);
        host.send(24'h001111, 24, 1, 1);
        host.send(24'h002222, 24, 0, 0);
        wait_out(2'h0, 16'h1111);
        // Core stalls while two frames queue up
        core_ready <= 1'b0;
        host.send(24'h003333, 24, 1, 0);
        host.send(24'h004444, 24, 1, 0);
        chk(code, 16'h1111);
        rd_chk(8'h04, 32'h00000018);
        core_ready <= 1'b1;
        wait_out(2'h0, 16'h4444);
        rd_chk(8'h0C, 32'h0000000A);
        // Disabled port ignores a whole frame
        apb(1'b1, 8'h08, 32'h00000000, rd, err);
        host.send(24'h005A5A, 24, 1, 0);
        chk(code, 16'h4444);
        apb(1'b1, 8'h08, 32'h00000001, rd, err);
        // Short frame reaches only the 12-bit port; the long port sees a cut frame
        host.send({16'h2ABC, 8'h00}, 16, 1, 0);
        chk({mode2, code2}, {2'h0, 16'h0AAF});
        chk(code, 16'h4444);
        host.send({16'h4000, 8'h00}, 16, 1, 0);
        chk({mode2, code2}, {2'h1, 16'h0AAF});
        end_of_test();
    end
endmodule : testbench
